/* File: bench/dasr_chk.sv */
/*
  Checker for the dual converter readout: busy, pair latch, power-down,
  span and serial output timing. Assumes the pins of dasr_top only.
*/
`timescale 1ns/1ps
module dasr_chk #(parameter CONV_CYCLES = 125) (
  input wire       sys_clk_in,
  input wire       rst_in,
  input wire       cs_n_in,
  input wire       sclk_in,
  input wire       conversion_trigger_in,
  input wire       span_select_low_in,
  input wire       span_select_high_in,
  input wire       busy_out,
  input wire       power_down_out,
  input wire       mux_pair_out,
  input wire       serial_result_out_a,
  input wire       serial_result_out_a_oe,
  input wire       serial_result_out_b,
  input wire       serial_result_out_b_oe,
  input wire [1:0] span_out
);
  int unsigned busy_len;
  // Count cycles of one busy period
  always @(posedge sys_clk_in) busy_len <= (rst_in || !busy_out) ? 0 : busy_len + 1;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // ****************************************
  // Sequences and assertions
  // ****************************************
  sequence s_cs_idle; cs_n_in [*4]; endsequence
  sequence s_sclk_still; (sclk_in && !cs_n_in) [*5]; endsequence
  conv_len_a: assert property ($fell(busy_out) |-> busy_len == CONV_CYCLES)
    else $error("busy length wrong");
  pair_hold_a: assert property (busy_out [*3] |-> $stable(mux_pair_out))
    else $error("pair changed in conversion");
  oe_release_a: assert property (s_cs_idle |-> !serial_result_out_a_oe && !serial_result_out_b_oe)
    else $error("output driven while deselected");
  oe_match_a: assert property (serial_result_out_a_oe == serial_result_out_b_oe)
    else $error("output enables differ");
  shift_edge_a: assert property (s_sclk_still |=> $stable({serial_result_out_a, serial_result_out_b}))
    else $error("data moved without falling edge");
  start_busy_a: assert property ($fell(conversion_trigger_in) && !busy_out && !power_down_out
    |-> ##[2:5] busy_out) else $error("trigger did not start");
  power_down_a: assert property ($fell(busy_out) && !conversion_trigger_in |-> ##[0:3] power_down_out)
    else $error("no power-down");
  wake_up_a: assert property ($rose(conversion_trigger_in) && power_down_out |-> ##[2:5] !power_down_out)
    else $error("no wake up");
  span_follow_a: assert property (
    ($stable({span_select_high_in, span_select_low_in}) && !$past(rst_in)) [*3]
    |-> span_out == {span_select_high_in, span_select_low_in}) else $error("span wrong");
endmodule // dasr_chk
bind dasr_top dasr_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.*);

/* File: bench/dasr_host.sv */
/*
  Host serial port model: frames with chip select, makes the serial clock.
  Assumes a 160 ns serial clock that stands low outside frames.
*/
`timescale 1ns/1ps
module dasr_host (
  output logic        cs_n_out,
  output logic        sclk_out,
  input  wire logic   dat_a_in,
  input  wire logic   dat_b_in
);
  logic [27:0] rx_a, rx_b;
  // Idle: deselected, clock still
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
  end
  // Read n bits, sampling on each rising edge
  task automatic read_frame(input int n);
    rx_a = 28'h0;
    rx_b = 28'h0;
    cs_n_out = 1'b0;
    repeat (n) begin
      #80 sclk_out = 1'b1;
      rx_a = {rx_a[26:0], dat_a_in};
      rx_b = {rx_b[26:0], dat_b_in};
      #80 sclk_out = 1'b0;
    end
    #80 cs_n_out = 1'b1;
  endtask
endmodule // dasr_host

/* File: bench/tb_dual_adc_serial_readout.sv */
/*
  Testbench: fills the word buffer, runs conversions, reads both outputs.
  Assumes dasr_top, dasr_host and the bound checker.
*/
`timescale 1ns/1ps
module tb_dual_adc_serial_readout;
  logic        sys_clk_in, rst_in, cs_n, sclk, trig, pair, sp_lo, sp_hi, vld, rdy, busy, pd, mux, da, db, oa, ob;
  logic        hold;
  logic [13:0] wa, wb;
  logic [1:0]  span;
  logic [27:0] q[$];
  int          failures, comparisons, cyc, n, i, nb;
  dasr_top #(.CONV_CYCLES(4)) u_dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .cs_n_in(cs_n), .sclk_in(sclk),
    .conversion_trigger_in(trig), .pair_select_in(pair), .span_select_low_in(sp_lo), .span_select_high_in(sp_hi),
    .core_word_a_in(wa), .core_word_b_in(wb), .core_valid_in(vld), .core_ready_out(rdy), .busy_out(busy),
    .power_down_out(pd), .hold_out(hold), .mux_pair_out(mux), .span_out(span), .serial_result_out_a(da),
    .serial_result_out_a_oe(oa), .serial_result_out_b(db), .serial_result_out_b_oe(ob));
  // A released data line shows the inverse of its last bit, so a sample taken undriven fails
  dasr_host u_host (.cs_n_out(cs_n), .sclk_out(sclk), .dat_a_in(oa ? da : ~da), .dat_b_in(ob ? db : ~db));
  // Clock and hang guard
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [27:0] e, input logic [27:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Expected frame: both words for a long read, the first word alone for a short one
  function automatic logic [27:0] exp_frame(input logic [27:0] w, input int bits);
    return (bits == 28) ? w : {14'h0, w[27:14]};
  endfunction
  task automatic wait_busy(input logic lvl);
    n = 0;
    while (busy !== lvl && n < 50) begin
      @(negedge sys_clk_in);
      n++;
    end
    chk("busy", {27'h0, lvl}, {27'h0, busy});
  endtask
  task automatic end_sim();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst_in, trig, pair, sp_lo, sp_hi, vld, wa, wb} = {6'h30, 28'h0};
    void'($urandom(32'hFFCC68E7));
    repeat (4) @(negedge sys_clk_in);
    rst_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    chk("reset", 28'h0, {busy, pd, oa, ob});
    for (i = 0; i < 17; i++) begin
      wa = (i == 0) ? 14'h3FFF : 14'($urandom);
      wb = (i == 0) ? 14'h0000 : 14'($urandom);
      vld = 1'b1;
      #1 if (rdy) q.push_back({wa, wb});
      @(negedge sys_clk_in);
    end
    vld = 1'b0;
    chk("filled", 28'h10, 28'(q.size()));
    $display("test fill done");
    for (i = 0; i < 16; i++) begin
      {pair, sp_hi, sp_lo} = 3'($urandom);
      trig = 1'b0;
      repeat (2) @(negedge sys_clk_in);
      trig = (i == 15) ? 1'b0 : 1'b1;
      wait_busy(1'b1);
      @(negedge sys_clk_in);
      chk("pair", {27'h0, pair}, {27'h0, mux});
      chk("span", {26'h0, sp_hi, sp_lo}, {26'h0, span});
      chk("hold", 28'h1, {27'h0, hold});
      pair = ~pair;
      wait_busy(1'b0);
      chk("hold off", 28'h0, {27'h0, hold});
      nb = (i % 3 == 1) ? 14 : 28;
      u_host.read_frame(nb);
      chk("out_a", exp_frame(q[0], nb), u_host.rx_a);
      chk("out_b", exp_frame({q[0][13:0], q[0][27:14]}, nb), u_host.rx_b);
      void'(q.pop_front());
      repeat (5) @(negedge sys_clk_in);
      chk("oe", 28'h0, {oa, ob});
      $display("test conversion %0d done", i);
    end
    chk("pd on", 28'h1, {27'h0, pd});
    trig = 1'b1;
    repeat (8) @(negedge sys_clk_in);
    chk("pd off", 28'h0, {27'h0, pd});
    chk("ready", 28'h1, {27'h0, rdy});
    $display("test power-down done");
    end_sim();
  end
endmodule // tb_dual_adc_serial_readout

/* File: common/dasr_consts.vh */
/*
  Constants for the dual converter serial readout block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef DASR_CONSTS_VH
`define DASR_CONSTS_VH
// ****************************************
// Word, timing, buffer and pair constants
// ****************************************
`define DASR_WORD_BITS      14
`define DASR_CONV_TIME_NS   1000
`define DASR_CLK_PERIOD_NS  8
`define DASR_CONV_CYCLES    ((`DASR_CONV_TIME_NS + `DASR_CLK_PERIOD_NS - 1) / `DASR_CLK_PERIOD_NS)
`define DASR_FIFO_DEPTH     16
`define DASR_FIFO_AW        4
`define DASR_PAIR_CH1       1'h0
`define DASR_PAIR_CH2       1'h1
`endif

/* File: verilog/dasr_fifo.v */
/*
  Synchronous FIFO with valid/ready on both sides, flip-flop storage.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module dasr_fifo #(
  parameter WIDTH = 28,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_in,
  input  wire             rst_in,
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire             rd_valid_out,
  input  wire             rd_ready_in
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            do_wr;
  wire            do_rd;
  wire [AW:0]     next_count;
  reg             wr_room;

  // Handshake terms; the room flag is a flop so ready leaves the top registered
  assign wr_ready_out = wr_room;
  assign next_count   = count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
  assign rd_valid_out = (count != {(AW+1){1'b0}});
  assign rd_data_out  = mem[rd_ptr];
  assign do_wr        = wr_valid_in & wr_ready_out;
  assign do_rd        = rd_valid_out & rd_ready_in;

  // Storage write
  always @(posedge clk_in) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr_data_in;
    end
  end

  // Pointers and fill count
  always @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
      wr_room <= 1'b1;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      count   <= next_count;
      wr_room <= (next_count != DEPTH[AW:0]);
    end
  end
endmodule // dasr_fifo

/* File: verilog/dasr_top.v */
/*
  Digital readout of a dual simultaneous-sampling converter: trigger,
  busy, channel-pair latch, power-down and two serial result outputs.
  Assumes the host drives chip select, serial clock and trigger
  asynchronously; all three pass two flip-flops first. Sample words
  come from the analog core on a valid/ready port through a FIFO.
*/
// Functional notes
// - Shift result bits on serial clock falling edge.
// - Word is 12 or 14 bits.
// - Both converters' words appear simultaneously.
// - Most significant bit sent first.
// - Extra word clocks give other converter's word.
// - Pair select picks channel 1 or 2.
// - Pair select latched on busy rising edge.
// - Two span inputs set range for all.
// - Outputs active only while chip select low.
// - Trigger falling edge starts both conversions.
// - Busy high from start until complete.
// - Trigger low at end enters power-down.
`timescale 1ns/1ps
`include "dasr_consts.vh"
module dasr_top #(
  parameter WORD_BITS   = `DASR_WORD_BITS,
  parameter CONV_CYCLES = `DASR_CONV_CYCLES
) (
  input  wire                   sys_clk_in,
  input  wire                   rst_in,
  input  wire                   cs_n_in,
  input  wire                   sclk_in,
  input  wire                   conversion_trigger_in,
  input  wire                   pair_select_in,
  input  wire                   span_select_low_in,
  input  wire                   span_select_high_in,
  input  wire [WORD_BITS-1:0]   core_word_a_in,
  input  wire [WORD_BITS-1:0]   core_word_b_in,
  input  wire                   core_valid_in,
  output wire                   core_ready_out,
  output reg                    busy_out,
  output reg                    power_down_out,
  output reg                    hold_out,
  output reg                    mux_pair_out,
  output reg  [1:0]             span_out,
  output reg                    serial_result_out_a,
  output reg                    serial_result_out_a_oe,
  output reg                    serial_result_out_b,
  output reg                    serial_result_out_b_oe
);
  // Counter widths: CW covers long conversions, BW two whole words
  localparam CW = 16;
  localparam BW = 5;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_CONV = 3'h2;
  localparam [2:0] ST_DOWN = 3'h4;

  // ****************************************
  // Input synchronisers
  // ****************************************
  reg [1:0] cs_sync;
  reg [1:0] sclk_sync;
  reg [1:0] trig_sync;
  reg       sclk_last;
  reg       trig_last;
  reg [1:0] pair_sync;
  reg [1:0] span_lo_sync;
  reg [1:0] span_hi_sync;
  // Host strobes: two flops each, then one more flop on clock and trigger for edge finding
  always @(posedge sys_clk_in) begin
    cs_sync   <= {cs_sync[0], cs_n_in};
    sclk_sync <= {sclk_sync[0], sclk_in};
    trig_sync <= {trig_sync[0], conversion_trigger_in};
    sclk_last <= sclk_sync[1];
    trig_last <= trig_sync[1];
  end
  // Board level inputs take the same two flops, so a level that moves
  // near a clock edge cannot split into two values inside the logic
  always @(posedge sys_clk_in) begin
    pair_sync    <= {pair_sync[0], pair_select_in};
    span_lo_sync <= {span_lo_sync[0], span_select_low_in};
    span_hi_sync <= {span_hi_sync[0], span_select_high_in};
  end
  // Only the second flop of each synchroniser feeds the logic
  wire cs_low    = ~cs_sync[1];
  wire sclk_fall = sclk_last & ~sclk_sync[1];
  wire trig_fall = trig_last & ~trig_sync[1];
  wire trig_rise = ~trig_last & trig_sync[1];

  // ****************************************
  // Sample FIFO between analog core and readout
  // ****************************************
  wire [2*WORD_BITS-1:0] fifo_data;
  wire                   fifo_valid;
  reg                    fifo_take;
  // Buffer lets the core run ahead of a slow host by a few word pairs
  dasr_fifo #(
    .WIDTH (2*WORD_BITS),
    .DEPTH (`DASR_FIFO_DEPTH),
    .AW    (`DASR_FIFO_AW)
  ) u_fifo (
    .clk_in       (sys_clk_in),
    .rst_in       (rst_in),
    .wr_data_in   ({core_word_a_in, core_word_b_in}),
    .wr_valid_in  (core_valid_in),
    .wr_ready_out (core_ready_out),
    .rd_data_out  (fifo_data),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (fifo_take)
  );

  // ****************************************
  // Conversion control
  // ****************************************
  reg [2:0]    state;
  reg [CW-1:0] conv_cnt;
  reg [WORD_BITS-1:0] res_a;
  reg [WORD_BITS-1:0] res_b;
  // A falling trigger edge in idle starts a fixed-length conversion. The pair
  // select is taken on the edge at which busy rises, so a change during
  // the conversion only steers the next one.
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      state          <= ST_IDLE;
      conv_cnt       <= {CW{1'b0}};
      busy_out       <= 1'b0;
      power_down_out <= 1'b0;
      hold_out       <= 1'b0;
      mux_pair_out   <= `DASR_PAIR_CH1;
      span_out       <= 2'h0;
      fifo_take      <= 1'b0;
      res_a          <= {WORD_BITS{1'b0}};
      res_b          <= {WORD_BITS{1'b0}};
    end else begin
      fifo_take <= 1'b0;
      span_out  <= {span_hi_sync[1], span_lo_sync[1]};
      case (state)
        ST_IDLE: begin
          if (trig_fall) begin
            state    <= ST_CONV;
            hold_out <= 1'b1;
            busy_out <= 1'b1;
            mux_pair_out <= pair_sync[1];
            conv_cnt <= CONV_CYCLES[CW-1:0];
          end
        end
        ST_CONV: begin
          if (conv_cnt > {{(CW-1){1'b0}}, 1'b1}) begin
            conv_cnt <= conv_cnt - 1'b1;
          end else begin
            busy_out <= 1'b0;
            hold_out <= 1'b0;
            // An empty buffer leaves the last words in place
            if (fifo_valid && !fifo_take) begin
              res_a     <= fifo_data[2*WORD_BITS-1:WORD_BITS];
              res_b     <= fifo_data[WORD_BITS-1:0];
              fifo_take <= 1'b1;
            end
            // Trigger still low at the end: stop until it rises again
            if (!trig_sync[1]) begin
              state          <= ST_DOWN;
              power_down_out <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_DOWN: begin
          if (trig_rise) begin
            state          <= ST_IDLE;
            power_down_out <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Serial readout
  // ****************************************
  reg [2*WORD_BITS-1:0] sh_a;
  reg [2*WORD_BITS-1:0] sh_b;
  reg [BW-1:0]          bit_cnt;
  reg                   framed;
  // The first bit of a frame is shown as soon as chip select is seen
  // low, so the host can take it on its first rising clock edge. Each
  // falling serial clock edge then advances one bit; edges past two
  // whole words leave the line on the last bit.
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      sh_a                   <= {2*WORD_BITS{1'b0}};
      sh_b                   <= {2*WORD_BITS{1'b0}};
      bit_cnt                <= {BW{1'b0}};
      framed                 <= 1'b0;
      serial_result_out_a    <= 1'b0;
      serial_result_out_b    <= 1'b0;
      serial_result_out_a_oe <= 1'b0;
      serial_result_out_b_oe <= 1'b0;
    end else begin
      serial_result_out_a_oe <= cs_low;
      serial_result_out_b_oe <= cs_low;
      if (!cs_low) begin
        framed  <= 1'b0;
        bit_cnt <= {BW{1'b0}};
      end else if (!framed) begin
        // Load A then B on output A, B then A on output B
        framed <= 1'b1;
        sh_a   <= {res_a, res_b};
        sh_b   <= {res_b, res_a};
        serial_result_out_a <= res_a[WORD_BITS-1];
        serial_result_out_b <= res_b[WORD_BITS-1];
        bit_cnt <= {BW{1'b0}};
      end else if (sclk_fall && bit_cnt < 2*WORD_BITS-1) begin
        // Next bit after each falling edge, up to two words
        sh_a    <= {sh_a[2*WORD_BITS-2:0], 1'b0};
        sh_b    <= {sh_b[2*WORD_BITS-2:0], 1'b0};
        serial_result_out_a <= sh_a[2*WORD_BITS-2];
        serial_result_out_b <= sh_b[2*WORD_BITS-2];
        bit_cnt <= bit_cnt + 1'b1;
      end
    end
  end
endmodule // dasr_top
